// ==== hdl/cfp_mode_ctrl.sv ====
// Front-panel mode and display controller of a pulse/CW microwave counter.
// Assumes a keypad scanner giving one-cycle key pulses, a measurement engine
// reporting results in kHz, and a display driver taking glyph writes.
`timescale 1ns/1ns
module cfp_mode_ctrl
    import cfp_pkg::*;
#(
    parameter logic [23:0] CF_MAX_KHZ = CF_MAX_KHZ_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic key_valid,
    input wire logic [3:0] key_code,
    input wire logic key_held,
    input wire logic pulse_mode,
    input wire logic level_warn,
    input wire logic meas_valid,
    input wire logic [23:0] meas_raw_khz,
    input wire logic sc_fail,
    input wire logic sc_done,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [1:0] mode,
    output logic front_end_on,
    output logic input2_sel,
    output logic input2_50ohm,
    output logic [1:0] fm_gate,
    output logic normal_rate_indicator,
    output logic low_rate_indicator,
    output logic track_indicator,
    output logic auto_indicator,
    output logic meas_start,
    output logic meas_abort,
    output logic sc_active,
    output logic sc_continue,
    output logic cf_error,
    output logic [23:0] center_frequency,
    output logic [2:0] msg_sel,
    output logic disp_wr,
    output logic [4:0] disp_pos,
    output logic [5:0] disp_glyph
);

    // Map a remote code to a glyph index 0..63 (code 32 is glyph 0)
    function automatic logic [5:0] glyph_of(input logic [6:0] code);
        logic [6:0] c;
        c = code;
        if (code < CODE_SPACE) begin
            c = CODE_SPACE;
        end else if (code >= CODE_LOWER_A && code <= CODE_LOWER_Z) begin
            c = code - CASE_OFS;
        end else if (code > CODE_LOWER_Z) begin
            c = code - CODE_ALIAS_OFS;
        end
        glyph_of = 6'(c - CODE_SPACE);
    endfunction

    // Drop the sub-megahertz part of a kHz value
    function automatic logic [23:0] trunc_mhz(input logic [23:0] khz);
        trunc_mhz = khz - (khz % KHZ_PER_MHZ);
    endfunction

    cfp_mode_e mode_q;
    cfp_mode_e mode_saved_q;
    cfp_fm_e fm_q;
    cfp_sc_e sc_q;
    logic hold_q;
    logic [23:0] entry_q;
    logic [23:0] last_meas_q;
    logic cf_show_q;
    logic [31:0] rdata_q;
    logic [4:0] dpos_q;
    logic [5:0] dglyph_q;
    logic dwr_q;
    logic start_q;
    logic abort_q;
    logic sc_cont_q;
    logic err_q;
    logic [23:0] cf_q;
    logic [2:0] msg_q;
    logic [4:0] digit_pos;
    logic key_mode_hit;
    cfp_mode_e key_mode;
    logic in_sc;
    logic fm_ok;

    assign in_sc = (sc_q != CFP_SC_IDLE);
    assign fm_ok = (mode_q == CFP_AUTO) && !pulse_mode;
    // Digit n sits at n + n/3, leaving one blank after each group of three
    assign digit_pos = 5'(reg_wdata[DISP_POS_LSB +: 4]) + 5'(reg_wdata[DISP_POS_LSB +: 4] / 4'h3);

    // Decode the measurement mode keys
    always_comb begin
        key_mode_hit = key_valid;
        key_mode = CFP_AUTO;
        case (key_code)
            KEY_AUTO: key_mode = CFP_AUTO;
            KEY_MANUAL: key_mode = CFP_MANUAL;
            KEY_LF50: key_mode = CFP_LF50;
            KEY_LF1M: key_mode = CFP_LF1M;
            default: key_mode_hit = 1'b0;
        endcase
    end

    // Measurement mode; self-check parks the previous one for later return
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= CFP_AUTO;
            mode_saved_q <= CFP_AUTO;
        end else if (key_mode_hit && !in_sc && key_mode != mode_q) begin
            mode_q <= key_mode;
        end else if (key_valid && key_code == KEY_SELFCHECK && !in_sc) begin
            mode_saved_q <= mode_q;
        end else if (key_valid && key_code == KEY_LOCAL && sc_q == CFP_SC_BYPASS) begin
            mode_q <= mode_saved_q;
        end
    end

    // Self-check sequencing with failure bypass
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sc_q <= CFP_SC_IDLE;
            sc_cont_q <= 1'b0;
            sc_active <= 1'b0;
        end else begin
            sc_cont_q <= 1'b0;
            sc_active <= (sc_q != CFP_SC_IDLE); // Registered, one cycle behind state
            case (sc_q)
                CFP_SC_IDLE: begin
                    if (key_valid && key_code == KEY_SELFCHECK) begin
                        sc_q <= CFP_SC_RUN;
                    end
                end
                CFP_SC_RUN: begin
                    if (sc_fail) begin
                        sc_q <= CFP_SC_FAILED;
                    end else if (sc_done) begin
                        sc_q <= CFP_SC_IDLE;
                    end
                end
                CFP_SC_FAILED: begin
                    if (key_valid && key_code == KEY_LOCAL) begin
                        sc_q <= CFP_SC_BYPASS;
                        sc_cont_q <= 1'b1;
                    end
                end
                CFP_SC_BYPASS: begin
                    // Local key wins so state and restored mode agree
                    if (key_valid && key_code == KEY_LOCAL) begin
                        sc_q <= CFP_SC_IDLE;
                    end else if (sc_fail) begin
                        sc_q <= CFP_SC_FAILED;
                    end
                end
                default: sc_q <= CFP_SC_IDLE;
            endcase
        end
    end

    // FM acquisition selection, advanced only where it has meaning
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fm_q <= CFP_FM_NORMAL;
        end else if (key_valid && key_code == KEY_FM && fm_ok) begin
            case (fm_q)
                CFP_FM_NORMAL: fm_q <= CFP_FM_LOW;
                CFP_FM_LOW: fm_q <= CFP_FM_TRACK;
                CFP_FM_TRACK: fm_q <= CFP_FM_NORMAL;
                default: fm_q <= CFP_FM_NORMAL;
            endcase
        end
    end

    // Front-end routing, gate selection and indicators
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            front_end_on <= 1'b1;
            input2_sel <= 1'b0;
            input2_50ohm <= 1'b0;
            fm_gate <= CFP_FM_NORMAL;
            normal_rate_indicator <= 1'b0;
            low_rate_indicator <= 1'b0;
            track_indicator <= 1'b0;
            auto_indicator <= 1'b0;
        end else begin
            front_end_on <= (mode_q == CFP_AUTO) || (mode_q == CFP_MANUAL);
            input2_sel <= (mode_q == CFP_LF50) || (mode_q == CFP_LF1M);
            input2_50ohm <= (mode_q == CFP_LF50);
            // Gate engine sees long gate for low rate, short for track
            fm_gate <= fm_ok ? fm_q : CFP_FM_NORMAL;
            normal_rate_indicator <= fm_ok && fm_q == CFP_FM_NORMAL;
            low_rate_indicator <= fm_ok && fm_q == CFP_FM_LOW;
            track_indicator <= fm_ok && fm_q == CFP_FM_TRACK;
            auto_indicator <= (mode_q == CFP_AUTO);
        end
    end

    // Trigger key: one shot in hold, abort and restart otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            start_q <= key_valid && key_code == KEY_TRIGGER;
            abort_q <= key_valid && key_code == KEY_TRIGGER && !hold_q;
        end
    end

    // Last raw result, taken before any offset or scale math
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_meas_q <= 24'h000000;
        end else if (meas_valid) begin
            last_meas_q <= meas_raw_khz;
        end
    end

    // Center-frequency entry, commit and range check
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cf_q <= CF_RST_KHZ;
            entry_q <= CF_RST_KHZ;
            err_q <= 1'b0;
        end else if (key_mode_hit && key_mode == CFP_MANUAL && mode_q != CFP_MANUAL
                     && !in_sc) begin
            cf_q <= last_meas_q;
            entry_q <= last_meas_q;
        end else if (key_valid && key_code == KEY_LAST_VALUE) begin
            entry_q <= last_meas_q;
        end else if (key_valid && key_code == KEY_ENTER) begin
            // Range check on the truncated value so 10000.9 MHz is accepted
            if (trunc_mhz(entry_q) < CF_MIN_KHZ || trunc_mhz(entry_q) > CF_MAX_KHZ) begin
                err_q <= 1'b1;
            end else begin
                cf_q <= trunc_mhz(entry_q);
            end
        end else if (key_valid && key_code == KEY_LOCAL && !in_sc) begin
            err_q <= 1'b0;
        end else if (reg_wr && reg_addr == REG_CF_ENTRY) begin
            entry_q <= reg_wdata[23:0];
        end
    end

    // Center frequency stays on display while the manual key that switched into manual mode is held
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cf_show_q <= 1'b0;
        end else if (key_mode_hit && key_mode == CFP_MANUAL && mode_q != CFP_MANUAL) begin
            cf_show_q <= 1'b1;
        end else if (!key_held) begin
            cf_show_q <= 1'b0;
        end
    end

    // Message section selection, error and self-check take priority
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            msg_q <= CFP_MSG_AUTO;
        end else if (in_sc) begin
            msg_q <= CFP_MSG_SELFCHECK;
        end else if (err_q) begin
            msg_q <= CFP_MSG_ERROR;
        end else if (cf_show_q) begin
            msg_q <= CFP_MSG_CF_SHOW;
        end else if (mode_q == CFP_LF50 || mode_q == CFP_LF1M) begin
            msg_q <= CFP_MSG_LF_INPUT;
        end else if (level_warn) begin
            msg_q <= CFP_MSG_LEVEL;
        end else begin
            msg_q <= (mode_q == CFP_AUTO) ? CFP_MSG_AUTO : CFP_MSG_MANUAL;
        end
    end

    // Hold control from software
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= CTRL_HOLD_RST;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            hold_q <= reg_wdata[CTRL_HOLD_BIT];
        end
    end

    // Remote display writes; out-of-range positions are dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dwr_q <= 1'b0;
            dpos_q <= 5'h00;
            dglyph_q <= 6'h00;
        end else begin
            dwr_q <= 1'b0;
            if (reg_wr && reg_addr == REG_DISP_CHAR
                && reg_wdata[DISP_POS_LSB +: 5] < 5'(DISP_CHARS)) begin
                dwr_q <= 1'b1;
                dpos_q <= reg_wdata[DISP_POS_LSB +: 5];
                dglyph_q <= glyph_of(reg_wdata[6:0]);
            end else if (reg_wr && reg_addr == REG_DISP_DIGIT
                         && reg_wdata[DISP_POS_LSB +: 4] < 4'(PARAM_DIGITS)) begin
                dwr_q <= 1'b1;
                dpos_q <= digit_pos;
                dglyph_q <= glyph_of(reg_wdata[6:0]);
            end
        end
    end

    // Read port, data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    REG_CTRL: rdata_q <= {31'h00000000, hold_q};
                    REG_CF_ENTRY: rdata_q <= {8'h00, entry_q};
                    REG_CF: rdata_q <= {8'h00, cf_q};
                    REG_STATUS: rdata_q <= {25'h0000000, err_q, sc_q, fm_q, mode_q};
                    REG_LAST_MEAS: rdata_q <= {8'h00, last_meas_q};
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign mode = mode_q;
    assign meas_start = start_q;
    assign meas_abort = abort_q;
    assign sc_continue = sc_cont_q;
    assign cf_error = err_q;
    assign center_frequency = cf_q;
    assign msg_sel = msg_q;
    assign disp_wr = dwr_q;
    assign disp_pos = dpos_q;
    assign disp_glyph = dglyph_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_bypass_continue: assert property (
        sc_q == CFP_SC_FAILED && key_valid && key_code == KEY_LOCAL
        |=> sc_continue && sc_q == CFP_SC_BYPASS)
        else $error("bypass did not continue self-check");
    a_bypass_return: assert property (
        sc_q == CFP_SC_BYPASS && !sc_fail && key_valid && key_code == KEY_LOCAL
        |=> mode_q == $past(mode_saved_q) && sc_q == CFP_SC_IDLE)
        else $error("mode not restored after bypass");
    a_fm_ignored: assert property (
        key_valid && key_code == KEY_FM && !fm_ok |=> $stable(fm_q))
        else $error("fm key acted outside auto cw");
    a_fm_cycle: assert property (
        key_valid && key_code == KEY_FM && fm_ok && fm_q == CFP_FM_TRACK
        |=> fm_q == CFP_FM_NORMAL)
        else $error("fm selection did not wrap");
    a_fm_onehot: assert property (
        ##1 (fm_ok && $stable(fm_q) && $stable(fm_ok)) |=> $onehot({normal_rate_indicator,
            low_rate_indicator, track_indicator}))
        else $error("fm indicators not one-hot");
    a_trig_hold: assert property (
        key_valid && key_code == KEY_TRIGGER && hold_q ##1 !key_valid
        |-> meas_start && !meas_abort ##1 !meas_start)
        else $error("hold trigger not a single start");
    a_trig_abort: assert property (
        key_valid && key_code == KEY_TRIGGER && !hold_q |=> meas_start && meas_abort)
        else $error("trigger did not abort and restart");
    a_lf_frontend: assert property (
        mode_q == CFP_LF50 |=> !front_end_on && input2_sel && input2_50ohm)
        else $error("front end on in low-frequency mode");
    a_same_key: assert property (
        key_mode_hit && key_mode == mode_q |=> mode_q == $past(mode_q))
        else $error("active mode key changed mode");
    a_cf_range: assert property (
        key_valid && key_code == KEY_ENTER && trunc_mhz(entry_q) < CF_MIN_KHZ
        && !(key_mode_hit) |=> err_q && $stable(cf_q))
        else $error("low center frequency accepted");

endmodule

// ==== pkg/cfp_pkg.sv ====
// Constants and types for the counter front-panel mode controller.
// Assumes one 250 MHz clock; frequencies are carried in kHz.
package cfp_pkg;
    // Measurement modes, binary coded so all four codes are legal
    typedef enum logic [1:0] {
        CFP_AUTO = 2'b00,
        CFP_MANUAL = 2'b01,
        CFP_LF50 = 2'b10,
        CFP_LF1M = 2'b11
    } cfp_mode_e;
    // FM acquisition selections
    typedef enum logic [1:0] {
        CFP_FM_NORMAL = 2'b00,
        CFP_FM_LOW = 2'b01,
        CFP_FM_TRACK = 2'b10
    } cfp_fm_e;
    // Self-check sequencing
    typedef enum logic [1:0] {
        CFP_SC_IDLE = 2'b00,
        CFP_SC_RUN = 2'b01,
        CFP_SC_FAILED = 2'b10,
        CFP_SC_BYPASS = 2'b11
    } cfp_sc_e;
    // Message section contents
    typedef enum logic [2:0] {
        CFP_MSG_AUTO = 3'b000,
        CFP_MSG_MANUAL = 3'b001,
        CFP_MSG_LF_INPUT = 3'b010,
        CFP_MSG_LEVEL = 3'b011,
        CFP_MSG_ERROR = 3'b100,
        CFP_MSG_SELFCHECK = 3'b101,
        CFP_MSG_CF_SHOW = 3'b110
    } cfp_msg_e;
    // Key codes from the keypad scanner
    localparam logic [3:0] KEY_AUTO = 4'h0;
    localparam logic [3:0] KEY_MANUAL = 4'h1;
    localparam logic [3:0] KEY_LF50 = 4'h2;
    localparam logic [3:0] KEY_LF1M = 4'h3;
    localparam logic [3:0] KEY_FM = 4'h4;
    localparam logic [3:0] KEY_TRIGGER = 4'h5;
    localparam logic [3:0] KEY_LOCAL = 4'h6;
    localparam logic [3:0] KEY_LAST_VALUE = 4'h7;
    localparam logic [3:0] KEY_ENTER = 4'h8;
    localparam logic [3:0] KEY_SELFCHECK = 4'h9;
    // Register offsets on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CF_ENTRY = 4'h1;
    localparam logic [3:0] REG_CF = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_DISP_CHAR = 4'h4;
    localparam logic [3:0] REG_DISP_DIGIT = 4'h5;
    localparam logic [3:0] REG_LAST_MEAS = 4'h6;
    // Field positions
    localparam int CTRL_HOLD_BIT = 0;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_FM_LSB = 2;
    localparam int ST_SC_LSB = 4;
    localparam int ST_ERR_BIT = 6;
    localparam int DISP_POS_LSB = 8;
    // Reset values
    localparam logic CTRL_HOLD_RST = 1'b0;
    localparam logic [23:0] CF_RST_KHZ = 24'h0f4240;
    // Frequency limits and units, kHz
    localparam logic [23:0] CF_MIN_KHZ = 24'h07a120;
    localparam logic [23:0] CF_MAX_KHZ_DEF = 24'h989680;
    localparam logic [23:0] KHZ_PER_MHZ = 24'h0003e8;
    // Display geometry
    localparam int DISP_CHARS = 24;
    localparam int PARAM_DIGITS = 12;
    localparam int MSG_CHARS = 8;
    localparam logic [4:0] MSG_FIRST_POS = 5'h10;
    // Character codes
    localparam logic [6:0] CODE_SPACE = 7'h20;
    localparam logic [6:0] CODE_LOWER_A = 7'h61;
    localparam logic [6:0] CODE_LOWER_Z = 7'h7a;
    localparam logic [6:0] CODE_ALIAS_OFS = 7'h40;
    localparam logic [6:0] CASE_OFS = 7'h20;
endpackage

// ==== bench/cfp_keypad_model.sv ====
// Keypad operator model: one-cycle key pulses plus a held level.
// Assumes the bench calls press and release_key from its main sequence.
`timescale 1ns/1ns
module cfp_keypad_model (
    input wire logic clock,
    output logic key_valid,
    output logic [3:0] key_code,
    output logic key_held
);
    // Idle state at time zero
    initial begin
        key_valid = 1'b0;
        key_code = 4'h5;
        key_held = 1'b0;
    end
    // Code lines go to the inverse after a press, so stale codes never match
    task automatic press(input logic [3:0] c, input logic held);
        @(posedge clock);
        key_valid <= 1'b1;
        key_code <= c;
        key_held <= held;
        @(posedge clock);
        key_valid <= 1'b0;
        key_code <= ~c;
    endtask
    // Operator lets go of a held key
    task automatic release_key();
        @(posedge clock);
        key_held <= 1'b0;
    endtask
endmodule

// ==== bench/test_counter_front_panel_mode_control.sv ====
// Self-checking bench for the front-panel mode controller.
// Assumes the keypad model in its own file; engine and register port driven here.
`timescale 1ns/1ns
module test_counter_front_panel_mode_control;
    import cfp_pkg::*;
    logic clock, rst_n, key_valid, key_held, pulse_mode, level_warn, meas_valid;
    logic sc_fail, sc_done, reg_wr, reg_rd, front_end_on, input2_sel, input2_50ohm;
    logic normal_rate_indicator, low_rate_indicator, track_indicator, auto_indicator;
    logic meas_start, meas_abort, sc_active, sc_continue, cf_error, disp_wr;
    logic [3:0] key_code, reg_addr;
    logic [23:0] meas_raw_khz, center_frequency;
    logic [31:0] reg_wdata, reg_rdata, st;
    logic [1:0] mode, fm_gate;
    logic [2:0] msg_sel;
    logic [4:0] disp_pos;
    logic [5:0] disp_glyph;
    int errors = 0;
    int num_checks = 0;
    logic [3:0] da [4] = '{REG_DISP_CHAR, REG_DISP_CHAR, REG_DISP_CHAR, REG_DISP_DIGIT};
    logic [31:0] dd [4] = '{32'h00000561, 32'h0000177b, 32'h0000007f, 32'h00000b37};
    logic [10:0] de [4] = '{{5'h05, 6'h21}, {5'h17, 6'h1b}, {5'h00, 6'h1f}, {5'h0e, 6'h17}};
    logic [23:0] bad [2] = '{24'h061a80, 24'h989a68};

    cfp_mode_ctrl i_cfp_mode_ctrl (.clock(clock), .rst_n(rst_n), .key_valid(key_valid),
        .key_code(key_code), .key_held(key_held), .pulse_mode(pulse_mode),
        .level_warn(level_warn), .meas_valid(meas_valid), .meas_raw_khz(meas_raw_khz),
        .sc_fail(sc_fail), .sc_done(sc_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode(mode),
        .front_end_on(front_end_on), .input2_sel(input2_sel), .input2_50ohm(input2_50ohm),
        .fm_gate(fm_gate), .normal_rate_indicator(normal_rate_indicator),
        .low_rate_indicator(low_rate_indicator), .track_indicator(track_indicator),
        .auto_indicator(auto_indicator), .meas_start(meas_start), .meas_abort(meas_abort),
        .sc_active(sc_active), .sc_continue(sc_continue), .cf_error(cf_error),
        .center_frequency(center_frequency), .msg_sel(msg_sel), .disp_wr(disp_wr),
        .disp_pos(disp_pos), .disp_glyph(disp_glyph));
    cfp_keypad_model i_cfp_keypad_model (.clock(clock), .key_valid(key_valid),
        .key_code(key_code), .key_held(key_held));

    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One-cycle write; state is settled when the task returns
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic key(input logic [3:0] c, input logic held);
        i_cfp_keypad_model.press(c, held);
        #1;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Measurement and self-check engine pulses
    task automatic engine(input logic f, input logic d, input logic m);
        @(posedge clock);
        sc_fail <= f;
        sc_done <= d;
        meas_valid <= m;
        @(posedge clock);
        sc_fail <= 1'b0;
        sc_done <= 1'b0;
        meas_valid <= 1'b0;
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog at 25000 cycles, far beyond the roughly 135 cycles the tests need
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        {pulse_mode, level_warn, meas_valid, sc_fail, sc_done, reg_wr, reg_rd} = 7'h00;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        meas_raw_khz = 24'h0f4c6b;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        step(2);
        chk(32'(mode), 32'(CFP_AUTO), "power-up mode");
        chk({29'h0, auto_indicator, front_end_on, normal_rate_indicator}, 32'h7, "power-up");
        chk(32'(center_frequency), 32'(CF_RST_KHZ), "cf reset");
        rd(REG_CTRL, st);
        chk(st, 32'(CTRL_HOLD_RST), "ctrl reset");
        $display("reset test done");
        // FM selection cycles through three states and back
        for (int i = 0; i < 3; i++) begin
            key(KEY_FM, 1'b0);
            step(1);
            chk(32'(fm_gate), 32'((i + 1) % 3), "fm gate");
            chk({normal_rate_indicator, low_rate_indicator, track_indicator},
                32'(3'b100 >> ((i + 1) % 3)), "fm indicators");
        end
        @(posedge clock);
        pulse_mode <= 1'b1;
        key(KEY_FM, 1'b0);
        step(1);
        chk({normal_rate_indicator, low_rate_indicator, track_indicator}, 0, "pulse");
        rd(REG_STATUS, st);
        chk(32'(st[3:2]), 32'(CFP_FM_NORMAL), "fm in pulse");
        @(posedge clock);
        pulse_mode <= 1'b0;
        $display("fm test done");
        key(KEY_TRIGGER, 1'b0);
        chk({meas_start, meas_abort}, 32'h3, "trigger running");
        wr(REG_CTRL, 32'h1);
        key(KEY_TRIGGER, 1'b0);
        chk({meas_start, meas_abort}, 32'h2, "trigger hold");
        step(1);
        chk({meas_start, meas_abort}, 32'h0, "single start");
        wr(REG_CTRL, 32'h0);
        $display("trigger test done");
        engine(1'b0, 1'b0, 1'b1);
        key(KEY_MANUAL, 1'b1);
        chk({mode, center_frequency}, {CFP_MANUAL, meas_raw_khz}, "manual copy");
        step(1);
        chk(32'(msg_sel), 32'(CFP_MSG_CF_SHOW), "cf shown while held");
        i_cfp_keypad_model.release_key();
        step(2);
        chk(32'(msg_sel), 32'(CFP_MSG_MANUAL), "manual message");
        key(KEY_MANUAL, 1'b0);
        key(KEY_FM, 1'b0);
        rd(REG_STATUS, st);
        chk(st[3:0], {CFP_FM_NORMAL, CFP_MANUAL}, "same key and fm in manual");
        @(posedge clock);
        level_warn <= 1'b1;
        step(2);
        chk(32'(msg_sel), 32'(CFP_MSG_LEVEL), "level warning");
        @(posedge clock);
        level_warn <= 1'b0;
        $display("manual test done");
        wr(REG_CF_ENTRY, 32'h0012d687);
        key(KEY_ENTER, 1'b0);
        chk(32'(center_frequency), 32'h0012d450, "trunc");
        wr(REG_CF_ENTRY, 32'(CF_MIN_KHZ));
        key(KEY_ENTER, 1'b0);
        chk({cf_error, center_frequency}, {1'b0, CF_MIN_KHZ}, "lower edge");
        for (int i = 0; i < 2; i++) begin
            wr(REG_CF_ENTRY, 32'(bad[i]));
            key(KEY_ENTER, 1'b0);
            chk({cf_error, center_frequency}, {1'b1, CF_MIN_KHZ}, "range error");
            step(1);
            chk(32'(msg_sel), 32'(CFP_MSG_ERROR), "error shown");
            key(KEY_LOCAL, 1'b0);
            chk(32'(cf_error), 0, "error cleared");
        end
        key(KEY_LAST_VALUE, 1'b0);
        key(KEY_ENTER, 1'b0);
        chk(32'(center_frequency), 32'h000f4a10, "lv");
        rd(REG_CF, st);
        chk(st, 32'h000f4a10, "cf register");
        $display("center test done");
        key(KEY_LF50, 1'b0);
        step(2);
        chk({mode, front_end_on, input2_sel, input2_50ohm}, {CFP_LF50, 3'b011}, "50");
        chk(32'(msg_sel), 32'(CFP_MSG_LF_INPUT), "input2 message");
        key(KEY_LF1M, 1'b0);
        key(KEY_LF1M, 1'b0);
        step(2);
        chk({mode, front_end_on, input2_sel, input2_50ohm}, {CFP_LF1M, 3'b010}, "1m");
        $display("low frequency test done");
        key(KEY_SELFCHECK, 1'b0);
        key(KEY_AUTO, 1'b0);
        chk({sc_active, mode}, {1'b1, CFP_LF1M}, "self-check running");
        engine(1'b1, 1'b0, 1'b0);
        key(KEY_LOCAL, 1'b0);
        chk(32'(sc_continue), 1, "bypass");
        engine(1'b0, 1'b1, 1'b0);
        step(1);
        chk(32'(sc_active), 1, "waits after last test");
        key(KEY_LOCAL, 1'b0);
        step(1);
        chk({sc_active, mode}, {1'b0, CFP_LF1M}, "previous mode back");
        key(KEY_AUTO, 1'b0);
        step(2);
        chk({mode, auto_indicator, front_end_on}, {CFP_AUTO, 2'b11}, "auto again");
        $display("self-check test done");
        // Glyph writes: lower case, high alias, top code, grouped digit
        for (int i = 0; i < 4; i++) begin
            wr(da[i], dd[i]);
            chk({disp_wr, disp_pos, disp_glyph}, {1'b1, de[i]}, "display write");
            step(1);
            chk(32'(disp_wr), 0, "write pulse");
        end
        rd(4'hf, st);
        chk(st, 0, "unmapped read");
        $display("display test done");
        tally_and_finish();
    end
endmodule
